/* File: verilog/dbgp_pkg.sv */
package dbgp_pkg;

   // Six pin usage configurations; codes 6 and 7 are treated as debug off
   typedef enum logic [2:0] {
      USE_JTAG_SW        = 3'h0,
      USE_JTAG_SW_NOTRST = 3'h1,
      USE_JTAG_TRACE     = 3'h2,
      USE_SW             = 3'h3,
      USE_SW_SWV         = 3'h4,
      USE_OFF            = 3'h5
   } dbgp_usage_e;

   localparam dbgp_usage_e USAGE_RST = USE_JTAG_SW;

   // Which debug functions own their pins
   typedef struct packed {
      logic tdi;
      logic tdo;
      logic tck;
      logic tms;
   } dbgp_pinen_s;

   localparam dbgp_pinen_s PINEN_NONE = 4'h0;

   typedef enum logic [1:0] {
      SER_IDLE  = 2'h0,
      SER_START = 2'h1,
      SER_DATA  = 2'h2,
      SER_STOP  = 2'h3
   } dbgp_ser_e;

   localparam int WORD_W  = 8;
   localparam int NUM_TMR = 4;
   localparam int NUM_PIN = 4;

   // Positions in the four-pin vectors: bit3, bit4, bit5, bit6
   localparam int PIN_B3 = 0;
   localparam int PIN_B4 = 1;
   localparam int PIN_B5 = 2;
   localparam int PIN_B6 = 3;

   localparam int MCLK_PERIOD_NS = 40;
   localparam int TRACE_BIT_NS   = 400;
   localparam int TRACE_BIT_CYC  = (TRACE_BIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [3:0] TRACE_BIT_LAST = 4'(TRACE_BIT_CYC - 1);
   localparam logic [2:0] BIT_LAST       = 3'h7;
   localparam logic [3:0] DIV_RST        = 4'h0;
   localparam logic [2:0] BIT_RST        = 3'h0;

endpackage

/* File: verilog/dbgp_sync.sv */
`timescale 1ns/1ps
module dbgp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import dbgp_pkg::*;

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end

endmodule

/* File: verilog/dbgp_fifo2.sv */
`timescale 1ns/1ps
module dbgp_fifo2 #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   import dbgp_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

/* File: verilog/dbgp_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - One port, two-wire serial or four-wire JTAG
// - Trace words serialised onto the viewer pin
// - Bits 3 and 4 carry mode/data and clock
// - Bit 5 carries test output or trace
// - Bits 3 to 6 are debug after reset
// - Pin directions follow the selected protocol
// - Debug drivers on bits 3, 5 survive STOP
// - Debug clock pin limits low-power saving
// - Six selectable pin usage configurations
// - Watchdog stops while core is debug halted
// - Each timer chooses run or stop in halt
// - Other peripherals keep running during halt
module dbgp_top (
   input  wire logic                            MCLK,
   input  wire logic                            RESET,
   input  wire logic                            PORTB_BIT4_CLK,
   input  wire logic                            PORTB_BIT3_IN,
   output logic                                 PORTB_BIT3_OUT,
   output logic                                 PORTB_BIT3_OE_N,
   output logic                                 PORTB_BIT4_OUT,
   output logic                                 PORTB_BIT4_OE_N,
   input  wire logic                            PORTB_BIT5_IN,
   output logic                                 PORTB_BIT5_OUT,
   output logic                                 PORTB_BIT5_OE_N,
   input  wire logic                            PORTB_BIT6_IN,
   output logic                                 PORTB_BIT6_OUT,
   output logic                                 PORTB_BIT6_OE_N,
   input  wire dbgp_pkg::dbgp_usage_e           USAGE_SEL,
   input  wire logic [dbgp_pkg::NUM_PIN-1:0]    GPIO_OUT,
   input  wire logic [dbgp_pkg::NUM_PIN-1:0]    GPIO_DIR_OUT,
   output logic      [dbgp_pkg::NUM_PIN-1:0]    GPIO_IN,
   input  wire logic                            STOP_MODE,
   input  wire logic                            STANDBY_DRIVE_EN,
   output logic                                 LOWPWR_LIMITED,
   input  wire logic                            CORE_HALT,
   input  wire logic [dbgp_pkg::NUM_TMR-1:0]    TMR_HALT_STOP,
   output logic                                 WATCHDOG_COUNT_EN,
   output logic      [dbgp_pkg::NUM_TMR-1:0]    TMR_COUNT_EN,
   output logic                                 PERIPH_RUN,
   input  wire logic                            SWDIO_DRIVE,
   input  wire logic [dbgp_pkg::WORD_W-1:0]     TRACE_DATA,
   input  wire logic                            TRACE_VALID,
   output logic                                 TRACE_READY,
   output logic      [dbgp_pkg::WORD_W-1:0]     RX_DATA,
   output logic                                 RX_VALID,
   input  wire logic                            RX_READY,
   output logic                                 RX_OVERRUN
);
   import dbgp_pkg::*;

   // ---------------- Core domain: configuration ----------------

   dbgp_usage_e usage_q;
   dbgp_pinen_s pinen;
   logic        sw_mode;
   logic        jtag_mode;
   logic        swv_mode;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         usage_q <= USAGE_RST;
      end else begin
         usage_q <= USAGE_SEL;
      end
   end

   always_comb begin
      pinen = PINEN_NONE;
      unique case (usage_q)
         USE_JTAG_SW, USE_JTAG_SW_NOTRST, USE_JTAG_TRACE: begin
            pinen = '{tdi: 1'b1, tdo: 1'b1, tck: 1'b1, tms: 1'b1};
         end
         USE_SW: begin
            pinen = '{tdi: 1'b0, tdo: 1'b0, tck: 1'b1, tms: 1'b1};
         end
         USE_SW_SWV: begin
            pinen = '{tdi: 1'b0, tdo: 1'b1, tck: 1'b1, tms: 1'b1};
         end
         USE_OFF: begin
            pinen = PINEN_NONE;
         end
         default: begin
            pinen = PINEN_NONE;
         end
      endcase
   end

   // Combined JTAG+SW usages start in JTAG; serial-only usages use SW framing
   assign sw_mode   = (usage_q == USE_SW) || (usage_q == USE_SW_SWV);
   assign jtag_mode = pinen.tck && !sw_mode;
   assign swv_mode  = (usage_q == USE_SW_SWV);

   // ---------------- Halt and low-power status ----------------

   logic                wdog_en_q;
   logic [NUM_TMR-1:0]  tmr_en_q;
   logic                periph_q;
   logic                lowpwr_q;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         wdog_en_q <= 1'b1;
         periph_q  <= 1'b1;
      end else begin
         wdog_en_q <= !CORE_HALT;
         periph_q  <= 1'b1;
      end
   end

   genvar gt;
   generate
      for (gt = 0; gt < NUM_TMR; gt++) begin : g_tmr
         always_ff @(posedge MCLK) begin
            if (RESET) begin
               tmr_en_q[gt] <= 1'b1;
            end else begin
               tmr_en_q[gt] <= !(CORE_HALT && TMR_HALT_STOP[gt]);
            end
         end
      end
   endgenerate

   // A clock pin owned by debug keeps its input stage alive in standby
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         lowpwr_q <= 1'b1;
      end else begin
         lowpwr_q <= pinen.tck;
      end
   end

   assign WATCHDOG_COUNT_EN = wdog_en_q;
   assign TMR_COUNT_EN      = tmr_en_q;
   assign PERIPH_RUN        = periph_q;
   assign LOWPWR_LIMITED    = lowpwr_q;

   // ---------------- Link domain (debug clock on bit 4) ----------------

   logic             l_rst;
   logic             l_sw;
   logic             l_ack;
   logic [2:0]       l_bit_q;
   logic [WORD_W-1:0] l_shift_q;
   logic [WORD_W-1:0] l_hold_q;
   logic             l_req_q;
   logic             l_ovr_q;
   logic             l_out_q;
   logic             l_in;
   logic             l_shift_en;
   logic [WORD_W-1:0] l_word;
   logic             ack_q;

   dbgp_sync #(.W(3)) u_lsync (
      .clk (PORTB_BIT4_CLK),
      .d   ({RESET, sw_mode, ack_q}),
      .q   ({l_rst, l_sw, l_ack})
   );

   // Probe data is synchronous to its own clock, so it is sampled directly
   assign l_in       = l_sw ? PORTB_BIT3_IN : PORTB_BIT6_IN;
   assign l_shift_en = l_sw || !PORTB_BIT3_IN;
   assign l_word     = {l_in, l_shift_q[WORD_W-1:1]};

   always_ff @(posedge PORTB_BIT4_CLK) begin
      if (l_rst) begin
         l_shift_q <= '0;
         l_bit_q   <= BIT_RST;
      end else if (l_shift_en) begin
         l_shift_q <= l_word;
         l_bit_q   <= l_bit_q + 1'b1;
      end else begin
         l_bit_q   <= BIT_RST; // Mode-select high realigns the word
      end
   end

   // Word hand-off: hold stays stable until the core returns the toggle
   always_ff @(posedge PORTB_BIT4_CLK) begin
      if (l_rst) begin
         l_hold_q <= '0;
         l_req_q  <= 1'b0;
         l_ovr_q  <= 1'b0;
      end else if (l_shift_en && l_bit_q == BIT_LAST) begin
         if (l_req_q == l_ack) begin
            l_hold_q <= l_word;
            l_req_q  <= !l_req_q;
         end else begin
            l_ovr_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge PORTB_BIT4_CLK) begin
      if (l_rst) begin
         l_out_q <= 1'b0;
      end else begin
         l_out_q <= l_shift_q[0];
      end
   end

   // ---------------- Core side of the word crossing ----------------

   logic             c_req;
   logic             c_ovr;
   logic             pending;
   logic             take;
   logic [WORD_W-1:0] rx_data_q;
   logic             rx_valid_q;
   logic             rx_ovr_q;

   dbgp_sync #(.W(2)) u_csync (
      .clk (MCLK),
      .d   ({l_req_q, l_ovr_q}),
      .q   ({c_req, c_ovr})
   );

   assign pending = (c_req != ack_q);
   assign take    = pending && (!rx_valid_q || RX_READY);

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ack_q <= 1'b0;
      end else if (take) begin
         ack_q <= !ack_q;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rx_data_q  <= '0;
         rx_valid_q <= 1'b0;
      end else if (take) begin
         rx_data_q  <= l_hold_q;
         rx_valid_q <= 1'b1;
      end else if (RX_READY) begin
         rx_valid_q <= 1'b0;
      end
   end

   // Overrun is a level from the link; it clears only with a reset
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rx_ovr_q <= 1'b0;
      end else begin
         rx_ovr_q <= c_ovr;
      end
   end

   assign RX_DATA    = rx_data_q;
   assign RX_VALID   = rx_valid_q;
   assign RX_OVERRUN = rx_ovr_q;

   // ---------------- Trace path: buffer and serial viewer output ----------------

   logic             tb_valid;
   logic             tb_ready;
   logic [WORD_W-1:0] tb_data;
   dbgp_ser_e        ser_q;
   logic [3:0]       div_q;
   logic [2:0]       sbit_q;
   logic [WORD_W-1:0] sdat_q;
   logic             swv_q;
   logic             tick;

   dbgp_fifo2 #(.W(WORD_W), .DEPTH(2)) u_tbuf (
      .clk       (MCLK),
      .rst       (RESET),
      .in_valid  (TRACE_VALID),
      .in_ready  (TRACE_READY),
      .in_data   (TRACE_DATA),
      .out_valid (tb_valid),
      .out_ready (tb_ready),
      .out_data  (tb_data)
   );

   // The buffer drains only while the viewer pin is in use, so the source stalls otherwise
   assign tb_ready = swv_mode && (ser_q == SER_IDLE);
   assign tick     = (div_q == TRACE_BIT_LAST);

   always_ff @(posedge MCLK) begin
      if (RESET || ser_q == SER_IDLE || tick) begin
         div_q <= DIV_RST;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ser_q  <= SER_IDLE;
         sbit_q <= BIT_RST;
         sdat_q <= '0;
      end else begin
         unique case (ser_q)
            SER_IDLE: begin
               if (tb_valid && tb_ready) begin
                  sdat_q <= tb_data;
                  ser_q  <= SER_START;
               end
            end
            SER_START: begin
               if (tick) begin
                  sbit_q <= BIT_RST;
                  ser_q  <= SER_DATA;
               end
            end
            SER_DATA: begin
               if (tick) begin
                  sdat_q <= {1'b0, sdat_q[WORD_W-1:1]};
                  sbit_q <= sbit_q + 1'b1;
                  if (sbit_q == BIT_LAST) begin
                     ser_q <= SER_STOP;
                  end
               end
            end
            SER_STOP: begin
               if (tick) begin
                  ser_q <= SER_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         swv_q <= 1'b1;
      end else begin
         unique case (ser_q)
            SER_IDLE:  swv_q <= 1'b1;
            SER_START: swv_q <= 1'b0;
            SER_DATA:  swv_q <= sdat_q[0];
            SER_STOP:  swv_q <= 1'b1;
         endcase
      end
   end

   // ---------------- Pins ----------------

   logic [NUM_PIN-1:0] pin_raw;
   logic [NUM_PIN-1:0] gpio_in_q;
   logic               gpio_drive_ok;

   assign pin_raw = {PORTB_BIT6_IN, PORTB_BIT5_IN, PORTB_BIT4_CLK, PORTB_BIT3_IN};

   dbgp_sync #(.W(NUM_PIN)) u_psync (
      .clk (MCLK),
      .d   (pin_raw),
      .q   (gpio_in_q)
   );

   assign GPIO_IN = gpio_in_q;

   // General-purpose drivers obey the standby drive enable in STOP
   assign gpio_drive_ok = !STOP_MODE || STANDBY_DRIVE_EN;

   always_comb begin
      // Mode-select / serial data: input in JTAG, two-way in SW
      if (pinen.tms) begin
         PORTB_BIT3_OUT  = l_out_q;
         PORTB_BIT3_OE_N = !(sw_mode && SWDIO_DRIVE);
      end else begin
         PORTB_BIT3_OUT  = GPIO_OUT[PIN_B3];
         PORTB_BIT3_OE_N = !(GPIO_DIR_OUT[PIN_B3] && gpio_drive_ok);
      end
      // Clock is an input in both protocols
      if (pinen.tck) begin
         PORTB_BIT4_OUT  = 1'b0;
         PORTB_BIT4_OE_N = 1'b1;
      end else begin
         PORTB_BIT4_OUT  = GPIO_OUT[PIN_B4];
         PORTB_BIT4_OE_N = !(GPIO_DIR_OUT[PIN_B4] && gpio_drive_ok);
      end
      // Test data out or viewer trace, driven regardless of STOP
      if (pinen.tdo) begin
         PORTB_BIT5_OUT  = swv_mode ? swv_q : l_out_q;
         PORTB_BIT5_OE_N = 1'b0;
      end else begin
         PORTB_BIT5_OUT  = GPIO_OUT[PIN_B5];
         PORTB_BIT5_OE_N = !(GPIO_DIR_OUT[PIN_B5] && gpio_drive_ok);
      end
      // Test data in is an input only
      if (pinen.tdi) begin
         PORTB_BIT6_OUT  = 1'b0;
         PORTB_BIT6_OE_N = 1'b1;
      end else begin
         PORTB_BIT6_OUT  = GPIO_OUT[PIN_B6];
         PORTB_BIT6_OE_N = !(GPIO_DIR_OUT[PIN_B6] && gpio_drive_ok);
      end
   end

   // jtag_mode is kept for the pin view of the combined usages
   logic jtag_seen_q;
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         jtag_seen_q <= 1'b1;
      end else begin
         jtag_seen_q <= jtag_mode;
      end
   end

endmodule

/* File: tb/dbgp_top_sva.sv */
`timescale 1ns/1ps
module dbgp_top_sva (
   input wire logic                         MCLK,
   input wire logic                         RESET,
   input wire dbgp_pkg::dbgp_usage_e        USAGE_SEL,
   input wire logic [dbgp_pkg::NUM_PIN-1:0] GPIO_DIR_OUT,
   input wire logic                         STOP_MODE,
   input wire logic                         STANDBY_DRIVE_EN,
   input wire logic                         SWDIO_DRIVE,
   input wire logic                         PORTB_BIT3_OE_N,
   input wire logic                         PORTB_BIT4_OE_N,
   input wire logic                         PORTB_BIT5_OE_N,
   input wire logic                         LOWPWR_LIMITED,
   input wire logic                         CORE_HALT,
   input wire logic [dbgp_pkg::NUM_TMR-1:0] TMR_HALT_STOP,
   input wire logic                         WATCHDOG_COUNT_EN,
   input wire logic [dbgp_pkg::NUM_TMR-1:0] TMR_COUNT_EN,
   input wire logic                         TRACE_VALID,
   input wire logic                         TRACE_READY,
   input wire logic                         RX_VALID,
   input wire logic                         RX_READY,
   input wire logic                         RX_OVERRUN
);
   import dbgp_pkg::*;
   logic [2:0] use_q;
   logic       gp_drv;

   // Mirror of the usage register, so pin checks line up with its one-cycle delay
   always_ff @(posedge MCLK) begin
      use_q <= RESET ? USAGE_RST : USAGE_SEL;
   end
   assign gp_drv = !STOP_MODE || STANDBY_DRIVE_EN;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   property p_wdt_halt; 1 |=> WATCHDOG_COUNT_EN == !$past(CORE_HALT); endproperty
   a_wdt_halt: assert property (p_wdt_halt) else $error("watchdog enable wrong");
   property p_tmr_halt;
      1 |=> TMR_COUNT_EN == ~({NUM_TMR{$past(CORE_HALT)}} & $past(TMR_HALT_STOP));
   endproperty
   a_tmr_halt: assert property (p_tmr_halt) else $error("timer enable wrong");
   property p_lowpwr; 1 |-> ##2 LOWPWR_LIMITED == ($past(USAGE_SEL, 2) < USE_OFF); endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("low power flag wrong");
   property p_b5_drv; use_q inside {3'h0, 3'h1, 3'h2, 3'h4} |-> !PORTB_BIT5_OE_N; endproperty
   a_b5_drv: assert property (p_b5_drv) else $error("bit5 driver off");
   property p_b3_sw; use_q inside {3'h3, 3'h4} && SWDIO_DRIVE |-> !PORTB_BIT3_OE_N; endproperty
   a_b3_sw: assert property (p_b3_sw) else $error("bit3 not driven in serial use");
   property p_jtag_in; use_q < 3'h3 |-> PORTB_BIT3_OE_N && PORTB_BIT4_OE_N; endproperty
   a_jtag_in: assert property (p_jtag_in) else $error("jtag input driven");
   property p_gpio; use_q >= 3'h5 |-> PORTB_BIT3_OE_N == !(GPIO_DIR_OUT[0] && gp_drv); endproperty
   a_gpio: assert property (p_gpio) else $error("bit3 port drive wrong");
   property p_trace_full; $fell(TRACE_READY) |-> $past(TRACE_VALID); endproperty
   a_trace_full: assert property (p_trace_full) else $error("ready fell without a word");
   property p_rx_hold; RX_VALID && !RX_READY |=> RX_VALID; endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("received word lost");
   property p_ovr; RX_OVERRUN |=> RX_OVERRUN [*3]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun flag dropped");
endmodule

bind dbgp_top dbgp_top_sva i_sva (.*);

/* File: tb/dbgp_probe.sv */
`timescale 1ns/1ps
module dbgp_probe (
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // Clock stands low between frames; gap stretches the low phase of a slow probe
   task automatic tick(input logic m, input logic d, input int gap);
      tms = m;
      tdi = d;
      #(24 + gap);
      tck = 1'b1;
      #24;
      tck = 1'b0;
   endtask

   task automatic pulse(input int n);
      repeat (n) tick(1'b1, ~tdi, 0);
   endtask

   task automatic frame(input logic [7:0] w, input logic sw, input int gap);
      // Link framing follows usage two probe clocks late; idle clocks with
      // mode-select high realign the count (SW preamble assumes JTAG before)
      repeat (sw ? 2 : 3)
         tick(1'b1, ~tdi, gap);
      for (int i = 0; i < 8; i++) begin
         if (sw)
            tick(w[i], ~tdi, gap);
         else
            tick(1'b0, w[i], gap);
      end
      // Released lines must not keep the last bit
      tms = ~tms;
      tdi = ~tdi;
   endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import dbgp_pkg::*;
   logic                MCLK;
   logic                RESET = 1'b1;
   logic                STOP_MODE = 1'b0, STANDBY_DRIVE_EN = 1'b0, CORE_HALT = 1'b0;
   logic                SWDIO_DRIVE = 1'b0, TRACE_VALID = 1'b0, RX_READY = 1'b0;
   logic [WORD_W-1:0]   TRACE_DATA = 8'h00;
   logic [NUM_PIN-1:0]  GPIO_OUT = 4'h9, GPIO_DIR_OUT = 4'hb;
   logic [NUM_TMR-1:0]  TMR_HALT_STOP = 4'h0;
   dbgp_usage_e         USAGE_SEL = USE_JTAG_SW;
   logic                PORTB_BIT3_OUT, PORTB_BIT4_OUT, PORTB_BIT5_OUT, PORTB_BIT6_OUT;
   logic                PORTB_BIT3_OE_N, PORTB_BIT4_OE_N, PORTB_BIT5_OE_N, PORTB_BIT6_OE_N;
   logic                PORTB_BIT3_IN, PORTB_BIT4_CLK, PORTB_BIT5_IN, PORTB_BIT6_IN;
   logic                p_tck, p_tms, p_tdi;
   logic [NUM_PIN-1:0]  GPIO_IN;
   logic                LOWPWR_LIMITED, WATCHDOG_COUNT_EN, PERIPH_RUN;
   logic [NUM_TMR-1:0]  TMR_COUNT_EN;
   logic                TRACE_READY, RX_VALID, RX_OVERRUN;
   logic [WORD_W-1:0]   RX_DATA;
   int                  failures = 0, cmp_count = 0, cyc = 0;

   // Pin levels: the device wins where it drives, else the probe
   assign PORTB_BIT3_IN  = PORTB_BIT3_OE_N ? p_tms : PORTB_BIT3_OUT;
   assign PORTB_BIT4_CLK = PORTB_BIT4_OE_N ? p_tck : PORTB_BIT4_OUT;
   assign PORTB_BIT5_IN  = PORTB_BIT5_OE_N ? ~p_tdi : PORTB_BIT5_OUT;
   assign PORTB_BIT6_IN  = PORTB_BIT6_OE_N ? p_tdi : PORTB_BIT6_OUT;

   dbgp_probe i_probe (.tck(p_tck), .tms(p_tms), .tdi(p_tdi));
   dbgp_top i_dut (.*);

   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge MCLK) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic set_use(input dbgp_usage_e u);
      @(negedge MCLK);
      USAGE_SEL = u;
      repeat (3) @(negedge MCLK);
   endtask

   task automatic t_reset;
      chk("oe_n", {PORTB_BIT6_OE_N, PORTB_BIT5_OE_N, PORTB_BIT4_OE_N, PORTB_BIT3_OE_N}, 4'hb);
      chk("halt_en", {WATCHDOG_COUNT_EN, TMR_COUNT_EN, PERIPH_RUN}, 6'h3f);
      chk("idle", {LOWPWR_LIMITED, RX_VALID, RX_OVERRUN, TRACE_READY}, 4'h9);
   endtask

   task automatic t_usage;
      logic [3:0] en;
      for (int u = 0; u < 8; u++) begin
         set_use(dbgp_usage_e'(u[2:0]));
         en = (u < 3) ? 4'hf : (u == 3) ? 4'h3 : (u == 4) ? 4'h7 : 4'h0;
         chk("use_oe", {PORTB_BIT6_OE_N, PORTB_BIT5_OE_N, PORTB_BIT4_OE_N, PORTB_BIT3_OE_N},
             {en[3], ~en[2], en[1], en[0]});
         chk("lowpwr", LOWPWR_LIMITED, en[1]);
         if (!en[3]) begin
            chk("b6_out", PORTB_BIT6_OUT, GPIO_OUT[3]);
            chk("b6_in", GPIO_IN[3], GPIO_OUT[3]);
         end
      end
   endtask

   task automatic t_stop;
      SWDIO_DRIVE = 1'b1;
      STOP_MODE = 1'b1;
      set_use(USE_SW_SWV);
      chk("stop_oe", {PORTB_BIT6_OE_N, PORTB_BIT5_OE_N, PORTB_BIT3_OE_N}, 3'h4);
      STANDBY_DRIVE_EN = 1'b1;
      @(negedge MCLK);
      chk("stop_oe", {PORTB_BIT6_OE_N, PORTB_BIT5_OE_N, PORTB_BIT3_OE_N}, 3'h0);
      SWDIO_DRIVE = 1'b0;
      STOP_MODE = 1'b0;
   endtask

   task automatic t_halt;
      @(negedge MCLK);
      CORE_HALT = 1'b1;
      TMR_HALT_STOP = 4'h5;
      repeat (2) @(negedge MCLK);
      chk("halt", {WATCHDOG_COUNT_EN, TMR_COUNT_EN, PERIPH_RUN}, 6'h15);
      TMR_HALT_STOP = 4'ha;
      repeat (2) @(negedge MCLK);
      chk("tmr", TMR_COUNT_EN, 4'h5);
      CORE_HALT = 1'b0;
      repeat (2) @(negedge MCLK);
      chk("run", {WATCHDOG_COUNT_EN, TMR_COUNT_EN}, 5'h1f);
   endtask

   task automatic put_trace(input logic [7:0] w);
      @(negedge MCLK);
      TRACE_DATA = w;
      TRACE_VALID = 1'b1;
      while (TRACE_READY !== 1'b1) @(negedge MCLK);
      @(negedge MCLK);
      TRACE_VALID = 1'b0;
   endtask

   task automatic see_frame(input logic [7:0] w);
      int n = 0;
      while (PORTB_BIT5_OUT !== 1'b0 && n < 300) begin
         @(negedge MCLK);
         n++;
      end
      repeat (4) @(negedge MCLK);
      for (int i = 0; i < 10; i++) begin
         chk("swv_bit", PORTB_BIT5_OUT, (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : w[i-1]);
         if (i < 9)
            repeat (10) @(negedge MCLK);
      end
   endtask

   task automatic t_trace;
      set_use(USE_JTAG_SW);
      put_trace(8'h5a);
      put_trace(8'h81);
      chk("trace_full", TRACE_READY, 1'b0);
      set_use(USE_SW_SWV);
      see_frame(8'h5a);
      see_frame(8'h81);
      chk("trace_empty", TRACE_READY, 1'b1);
   endtask

   task automatic take_rx(input logic [7:0] w);
      int n = 0;
      while (RX_VALID !== 1'b1 && n < 40) begin
         @(negedge MCLK);
         n++;
      end
      chk("rx_data", RX_DATA, w);
      RX_READY = 1'b1;
      @(negedge MCLK);
      RX_READY = 1'b0;
      chk("rx_valid", RX_VALID, 1'b0);
   endtask

   // Usage is never changed while a frame is on the wire
   task automatic t_link;
      set_use(USE_JTAG_SW);
      i_probe.frame(8'h3c, 1'b0, 0);
      take_rx(8'h3c);
      set_use(USE_SW);
      i_probe.frame(8'hc5, 1'b1, 40);
      take_rx(8'hc5);
      chk("ovr", RX_OVERRUN, 1'b0);
      set_use(USE_JTAG_TRACE);
      i_probe.frame(8'h81, 1'b0, 0);
      i_probe.frame(8'h7e, 1'b0, 0);
      repeat (6) @(negedge MCLK);
      chk("stall", {RX_OVERRUN, RX_VALID, RX_DATA}, {2'h1, 8'h81});
      i_probe.frame(8'ha5, 1'b0, 0);
      repeat (6) @(negedge MCLK);
      chk("ovr_set", {RX_OVERRUN, RX_VALID, RX_DATA}, {2'h3, 8'h81});
   endtask

   initial begin
      fork
         i_probe.pulse(4);
         repeat (20) @(negedge MCLK);
      join
      RESET = 1'b0;
      t_reset();
      t_usage();
      t_stop();
      t_halt();
      t_trace();
      t_link();
      report_and_stop();
   end
endmodule
